// *** dv/sild_host.sv ***
/*
 * Host controller model: drives shift clock, serial data, strobe, enable.
 * Assumes a 25 MHz core clock; the shift clock runs at 8 core cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module sild_host (
    input wire logic core_clk_i,
    output logic sclk_o,
    output logic sdat_o,
    output logic stb_o,
    output logic en_o
);
    // All pins low and known well before reset is released
    initial {sclk_o, sdat_o, stb_o, en_o} = 4'h0;

    // Eight bits, first bit sent ends in the last stage; 320 ns per bit
    task automatic send(input logic [7:0] b);
        @(posedge core_clk_i);
        for (int i = 7; i >= 0; i--) begin
            sdat_o <= b[i];
            repeat (4) @(posedge core_clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge core_clk_i);
            sclk_o <= 1'b0;
        end
        sdat_o <= ~b[0]; // Hold over: no stale level
    endtask : send

    // Gap after the last shift clock, then new strobe and enable levels
    task automatic ctl(input logic s, input logic e);
        repeat (8) @(posedge core_clk_i);
        stb_o <= s;
        en_o <= e;
    endtask : ctl
endmodule : sild_host
`default_nettype wire

// *** dv/tb.sv ***
/*
 * Self-checking bench of the latched driver, random bytes plus corners.
 * Assumes sild_driver and sild_host are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sclk, sdat, stb, en, sdo;
    logic [7:0] drv;
    int n_errors = 0;
    int total_checks = 0;

    always #20 clk = ~clk;

    sild_driver i_sild_driver (.core_clk_i(clk), .rstn_i(rstn), .shift_clk_i(sclk), .ser_data_i(sdat),
        .strobe_i(stb), .enable_i(en), .ser_data_o(sdo), .drive_o(drv));
    sild_host i_sild_host (.core_clk_i(clk), .sclk_o(sclk), .sdat_o(sdat), .stb_o(stb), .en_o(en));

    // Drivers are off while enable is high
    function automatic logic [7:0] exp_drv(input logic e, input logic [7:0] l);
        return e ? 8'h00 : l;
    endfunction : exp_drv

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // Past the 3..4 cycle filter latency, off the clock edge
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask : settle

    // Watchdog: the whole run needs well under 100 us
    initial begin
        #400us;
        n_errors++;
        complete_run();
    end

    initial begin
        logic [7:0] b, old;
        old = 8'h00;
        b = 8'($urandom(25173));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        settle();
        check(drv, 8'h00);
        check({7'h00, sdo}, 8'h00);
        // Corner bytes first, then random ones
        for (int k = 0; k < 9; k++) begin
            b = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : (k == 2) ? 8'h5a : 8'($urandom());
            i_sild_host.send(b);
            settle();
            check({7'h00, sdo}, {7'h00, b[7]});
            check(drv, old);
            i_sild_host.ctl(1'b1, 1'b0);
            i_sild_host.ctl(1'b0, 1'b0);
            settle();
            check(drv, exp_drv(1'b0, b));
            old = b;
        end
        // Enable high: drivers off, new shifting must not reach latches
        i_sild_host.ctl(1'b0, 1'b1);
        settle();
        check(drv, exp_drv(1'b1, old));
        b = ~old;
        i_sild_host.send(b);
        i_sild_host.ctl(1'b0, 1'b0);
        settle();
        check(drv, old);
        i_sild_host.ctl(1'b1, 1'b0);
        i_sild_host.ctl(1'b0, 1'b0);
        settle();
        check(drv, b);
        // Strobe tied high, enable high through the entry
        i_sild_host.ctl(1'b1, 1'b1);
        i_sild_host.send(old);
        settle();
        check(drv, exp_drv(1'b1, old));
        i_sild_host.ctl(1'b1, 1'b0);
        settle();
        check(drv, old);
        // Mid-run reset with strobe still high: stored state clears
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        settle();
        check(drv, 8'h00);
        check({7'h00, sdo}, 8'h00);
        complete_run();
    end
endmodule : tb
`default_nettype wire

// *** hw/sild_consts.svh ***
/*
 * Constants of the serial-in latched output driver: stage count, input
 * slot positions in the synchroniser vectors, and timing figures.
 * Assumes the core clock runs at 25 MHz; included by bare name.
 */
`ifndef SILD_CONSTS_SVH
`define SILD_CONSTS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define SILD_STAGES 8
`define SILD_NUM_IN 4

// ****************************************************************
// Slot of each pin input in the synchroniser vectors
// ****************************************************************
`define SILD_IN_SCLK 0
`define SILD_IN_SDAT 1
`define SILD_IN_STB 2
`define SILD_IN_EN 3

// ****************************************************************
// Reset values
// ****************************************************************
`define SILD_RST_BYTE 8'h00
`define SILD_RST_IN 4'h0
`define SILD_RST_BIT 1'b0
// Driver word with every output switched off
`define SILD_DRV_OFF 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define SILD_CLK_PERIOD_NS 40
// Least gap from the last shift clock to the strobe (a host duty)
`define SILD_CLK_TO_STB_NS 300
`define SILD_CLK_TO_STB_CYC ((`SILD_CLK_TO_STB_NS + `SILD_CLK_PERIOD_NS - 1) / `SILD_CLK_PERIOD_NS)

`endif

// *** hw/sild_driver.sv ***
/*
 * Serial-in, latched eight-output driver: shift register, transparent
 * latches and output drivers, rebuilt on a fast core clock.
 * Assumes all four control pins are asynchronous to core_clk_i and that
 * the host shift clock is much slower (320 ns period in the bench).
 */
// Notes on behaviour
// - Rising shift clock loads data into stage one
// - Each rising edge moves stages toward output
// - Strobe high: latches follow shift stages
// - Enable high: outputs off, storage untouched
// - Enable low: outputs follow their latches
`timescale 1ns/1ps
`default_nettype none
`include "sild_consts.svh"

module sild_driver (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic shift_clk_i,
    input wire logic ser_data_i,
    input wire logic strobe_i,
    input wire logic enable_i,
    output logic ser_data_o,
    output logic [`SILD_STAGES-1:0] drive_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    sild_pkg::sild_state_type st_r;
    sild_pkg::sild_state_type st_nxt;
    logic sclk_rise;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // Pins pass three flops; a level counts once stages two and three agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync0 = {enable_i, strobe_i, ser_data_i, shift_clk_i};
        st_nxt.sync1 = st_r.sync0;
        st_nxt.sync2 = st_r.sync1;
        for (int i = 0; i < `SILD_NUM_IN; i++) begin
            if (st_r.sync1[i] == st_r.sync2[i]) begin
                st_nxt.filt[i] = st_r.sync1[i];
            end
        end

        // Data and clock share one pipeline, so they stay aligned
        sclk_rise = st_nxt.filt[`SILD_IN_SCLK] & ~st_r.filt[`SILD_IN_SCLK];
        if (sclk_rise) begin
            st_nxt.shreg = {st_r.shreg[`SILD_STAGES-2:0], st_nxt.filt[`SILD_IN_SDAT]};
        end

        // Latches see the stage value of this same cycle, as a wire would
        if (st_nxt.filt[`SILD_IN_STB]) begin
            st_nxt.latch = st_nxt.shreg;
        end else begin
            st_nxt.latch = st_r.latch;
        end

        // Enable only gates the drivers; stages and latches keep running
        if (st_nxt.filt[`SILD_IN_EN]) begin
            st_nxt.drive = `SILD_DRV_OFF;
        end else begin
            st_nxt.drive = st_nxt.latch;
        end
        st_nxt.sdo = st_nxt.shreg[`SILD_STAGES-1];
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Reset is ours alone: it clears everything so outputs start off
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r.sync0 <= `SILD_RST_IN;
            st_r.sync1 <= `SILD_RST_IN;
            st_r.sync2 <= `SILD_RST_IN;
            st_r.filt <= `SILD_RST_IN;
            st_r.shreg <= `SILD_RST_BYTE;
            st_r.latch <= `SILD_RST_BYTE;
            st_r.drive <= `SILD_RST_BYTE;
            st_r.sdo <= `SILD_RST_BIT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops
    assign ser_data_o = st_r.sdo;
    assign drive_o = st_r.drive;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Steps of a shift
    sequence edge_s;
        sclk_rise;
    endsequence

    sequence no_edge_s;
        !sclk_rise;
    endsequence

    // Filtered pin steps: low then high, or high then low
    sequence sclk_up_s;
        !st_r.filt[`SILD_IN_SCLK] ##1 st_r.filt[`SILD_IN_SCLK];
    endsequence

    sequence sclk_down_s;
        st_r.filt[`SILD_IN_SCLK] ##1 !st_r.filt[`SILD_IN_SCLK];
    endsequence

    sequence stb_up_s;
        !st_r.filt[`SILD_IN_STB] ##1 st_r.filt[`SILD_IN_STB];
    endsequence

    sequence stb_down_s;
        st_r.filt[`SILD_IN_STB] ##1 !st_r.filt[`SILD_IN_STB];
    endsequence

    sequence en_up_s;
        !st_r.filt[`SILD_IN_EN] ##1 st_r.filt[`SILD_IN_EN];
    endsequence

    sequence en_down_s;
        st_r.filt[`SILD_IN_EN] ##1 !st_r.filt[`SILD_IN_EN];
    endsequence

    shift_capture_a: assert property (
        edge_s |=> st_r.shreg[0] == $past(st_nxt.filt[`SILD_IN_SDAT]))
        else $error("first stage missed the serial bit");

    shift_move_a: assert property (
        edge_s |=> st_r.shreg[`SILD_STAGES-1:1] == $past(st_r.shreg[`SILD_STAGES-2:0]))
        else $error("stages did not move by one place");

    shift_idle_a: assert property (
        no_edge_s |=> $stable(st_r.shreg))
        else $error("stages moved without a shift clock edge");

    serial_out_a: assert property (
        ser_data_o == st_r.shreg[`SILD_STAGES-1])
        else $error("serial output is not the last stage");

    latch_follow_a: assert property (
        st_r.filt[`SILD_IN_STB] |-> st_r.latch == st_r.shreg)
        else $error("latches do not follow stages under strobe");

    latch_hold_a: assert property (
        !st_nxt.filt[`SILD_IN_STB] |=> $stable(st_r.latch))
        else $error("latches changed while strobe low");

    drive_off_a: assert property (
        st_r.filt[`SILD_IN_EN] |-> drive_o == `SILD_DRV_OFF)
        else $error("a driver is on while enable is high");

    enable_keep_a: assert property (
        st_nxt.filt[`SILD_IN_EN] && !sclk_rise && !st_nxt.filt[`SILD_IN_STB]
        |=> $stable(st_r.shreg) && $stable(st_r.latch))
        else $error("enable disturbed stored state");

    drive_follow_a: assert property (
        !st_r.filt[`SILD_IN_EN] |-> drive_o == st_r.latch)
        else $error("drivers do not follow the latches");

    // ****************************************************************
    // Pin step checks
    // ****************************************************************

    // Stages, latches and drivers register together, so each step lines up
    first_stage_a: assert property (
        sclk_up_s |-> st_r.shreg[0] == st_r.filt[`SILD_IN_SDAT])
        else $error("first stage differs from the filtered data");

    fall_ignore_a: assert property (
        sclk_down_s |-> $stable(st_r.shreg))
        else $error("a falling shift clock moved the stages");

    serial_shift_a: assert property (
        sclk_up_s |-> ser_data_o == $past(st_r.shreg[`SILD_STAGES-2]))
        else $error("serial output did not take the stage before");

    serial_hold_a: assert property (
        no_edge_s |=> $stable(ser_data_o))
        else $error("serial output changed without a shift");

    strobe_open_a: assert property (
        stb_up_s |-> drive_o == (st_r.filt[`SILD_IN_EN] ? `SILD_DRV_OFF : st_r.shreg))
        else $error("opening strobe did not pass the stages");

    latch_track_a: assert property (
        st_nxt.filt[`SILD_IN_STB] && sclk_rise |=> st_r.latch[0] == $past(st_nxt.filt[`SILD_IN_SDAT]))
        else $error("open latch missed a new serial bit");

    latch_keep_a: assert property (
        !st_r.filt[`SILD_IN_STB] && !st_nxt.filt[`SILD_IN_STB] |=> st_r.latch == $past(st_r.latch, 2))
        else $error("closed latches drifted");

    latch_shut_a: assert property (
        stb_down_s |-> $stable(st_r.latch))
        else $error("latches moved as the strobe fell");

    enable_rise_a: assert property (
        en_up_s |-> drive_o == `SILD_DRV_OFF)
        else $error("drivers stayed on as enable rose");

    enable_fall_a: assert property (
        en_down_s |-> drive_o == st_r.latch)
        else $error("drivers did not return to the latches");

    drive_subset_a: assert property (
        (drive_o & ~st_r.latch) == `SILD_DRV_OFF)
        else $error("a driver is on with its latch clear");

endmodule : sild_driver
`default_nettype wire

// *** hw/sild_pkg.sv ***
/*
 * Types of the serial-in latched output driver.
 * Assumes sild_consts.svh is on the include path.
 */
`include "sild_consts.svh"

package sild_pkg;

    // ****************************************************************
    // Whole state of the driver, registered as one word
    // ****************************************************************
    typedef struct packed {
        logic [`SILD_NUM_IN-1:0] sync0;  // First synchroniser stage
        logic [`SILD_NUM_IN-1:0] sync1;  // Second synchroniser stage
        logic [`SILD_NUM_IN-1:0] sync2;  // Third synchroniser stage
        logic [`SILD_NUM_IN-1:0] filt;   // Agreed input levels
        logic [`SILD_STAGES-1:0] shreg;  // Shift stages, bit 0 first
        logic [`SILD_STAGES-1:0] latch;  // Output latches
        logic [`SILD_STAGES-1:0] drive;  // Output drivers, 1 = on
        logic sdo;                       // Serial data output
    } sild_state_type;

endpackage : sild_pkg
